// File: hw/dcc_pkg.sv
/*
 * Constants shared by the dual comparator control block: field widths,
 * reset values and input multiplexer codes.
 * Assumes nothing of its surroundings.
 */
package dcc_pkg;

    // Field widths
    localparam int HYST_W = 2;
    localparam int MODE_W = 2;
    localparam int SEL_W  = 4;
    localparam int POS_PINS = 12;
    localparam int NEG_PINS = 11;

    // Reset values
    localparam logic              ENABLE_RST   = 1'b0;
    localparam logic              FLAG_RST     = 1'b0;
    localparam logic              IRQ_EN_RST   = 1'b0;
    localparam logic [HYST_W-1:0] HYST_RST     = 2'h0;
    localparam logic [MODE_W-1:0] MODE_RST     = 2'h2;
    localparam logic [SEL_W-1:0]  POS_SEL_RST  = 4'hf;
    localparam logic [SEL_W-1:0]  NEG_SEL_RST  = 4'hf;

    // Response modes: fastest, highest current first
    localparam logic [MODE_W-1:0] MODE_FASTEST = 2'h0;
    localparam logic [MODE_W-1:0] MODE_SLOWEST = 2'h3;

    // Hysteresis codes
    localparam logic [HYST_W-1:0] HYST_OFF     = 2'h0;
    localparam logic [HYST_W-1:0] HYST_MAX     = 2'h3;

    // Positive multiplexer codes
    localparam logic [SEL_W-1:0]  POS_PIN_LAST = 4'hb;
    localparam logic [SEL_W-1:0]  POS_CSENSE   = 4'hc;
    localparam logic [SEL_W-1:0]  POS_HALF     = 4'hd;
    localparam logic [SEL_W-1:0]  POS_SUPPLY_A = 4'he;
    localparam logic [SEL_W-1:0]  POS_SUPPLY_B = 4'hf;

    // Negative multiplexer codes
    localparam logic [SEL_W-1:0]  NEG_PIN_LAST = 4'ha;
    localparam logic [SEL_W-1:0]  NEG_RESERVED = 4'hb;
    localparam logic [SEL_W-1:0]  NEG_CSENSE   = 4'hc;
    localparam logic [SEL_W-1:0]  NEG_HALF     = 4'hd;
    localparam logic [SEL_W-1:0]  NEG_REGOUT   = 4'he;
    localparam logic [SEL_W-1:0]  NEG_GND      = 4'hf;

endpackage : dcc_pkg

// File: hw/dcc_top.sv
/*
 * Dual comparator control: settings registers, analog controls, input
 * multiplexer decode, output synchronisation, sticky edge flags, masked
 * edge interrupts and the comparator zero reset and kill triggers.
 * Assumes software write strobes and analog comparator outputs are
 * presented to it; raw outputs are taken as asynchronous to mclk.
 */
`timescale 1ns/1ps
module dcc_top #(
    parameter int N_CMP = 2
) (
    // Clock and reset
    input  wire logic                                  mclk,
    input  wire logic                                  rst_n,
    // Control write: enable, edge flags, hysteresis
    input  wire logic [N_CMP-1:0]                      ctrl_wr,
    input  wire logic [N_CMP-1:0]                      cmp_enable_bit,
    input  wire logic [N_CMP-1:0]                      rise_flag_wdata,
    input  wire logic [N_CMP-1:0]                      fall_flag_wdata,
    input  wire logic [N_CMP-1:0][dcc_pkg::HYST_W-1:0] pos_hysteresis_sel,
    input  wire logic [N_CMP-1:0][dcc_pkg::HYST_W-1:0] neg_hysteresis_sel,
    // Mode write: interrupt enables, response mode
    input  wire logic [N_CMP-1:0]                      mode_wr,
    input  wire logic [N_CMP-1:0]                      rise_irq_enable,
    input  wire logic [N_CMP-1:0]                      fall_irq_enable,
    input  wire logic [N_CMP-1:0][dcc_pkg::MODE_W-1:0] response_mode_sel,
    // Input select write
    input  wire logic [N_CMP-1:0]                      mux_wr,
    input  wire logic [N_CMP-1:0][dcc_pkg::SEL_W-1:0]  pos_input_sel,
    input  wire logic [N_CMP-1:0][dcc_pkg::SEL_W-1:0]  neg_input_sel,
    // Raw analog comparator outputs
    input  wire logic [N_CMP-1:0]                      cmp_raw,
    // Settings readback
    output logic      [N_CMP-1:0]                      enable_q,
    output logic      [N_CMP-1:0]                      rise_irq_enable_q,
    output logic      [N_CMP-1:0]                      fall_irq_enable_q,
    output logic      [N_CMP-1:0][dcc_pkg::MODE_W-1:0] response_mode_q,
    output logic      [N_CMP-1:0][dcc_pkg::SEL_W-1:0]  pos_input_sel_q,
    output logic      [N_CMP-1:0][dcc_pkg::SEL_W-1:0]  neg_input_sel_q,
    // Status
    output logic      [N_CMP-1:0]                      cmp_output_state,
    output logic      [N_CMP-1:0]                      rise_edge_flag,
    output logic      [N_CMP-1:0]                      fall_edge_flag,
    output logic      [N_CMP-1:0]                      cmp_irq,
    // Analog controls
    output logic      [N_CMP-1:0]                      cmp_power_en,
    output logic      [N_CMP-1:0][dcc_pkg::MODE_W-1:0] supply_current_sel,
    output logic      [N_CMP-1:0][dcc_pkg::HYST_W-1:0] pos_hyst_ctl,
    output logic      [N_CMP-1:0][dcc_pkg::HYST_W-1:0] neg_hyst_ctl,
    output logic      [N_CMP-1:0][dcc_pkg::POS_PINS-1:0] pos_pin_sel,
    output logic      [N_CMP-1:0]                      pos_csense_sel,
    output logic      [N_CMP-1:0]                      pos_half_sel,
    output logic      [N_CMP-1:0]                      pos_supply_sel,
    output logic      [N_CMP-1:0][dcc_pkg::NEG_PINS-1:0] neg_pin_sel,
    output logic      [N_CMP-1:0]                      neg_csense_sel,
    output logic      [N_CMP-1:0]                      neg_half_sel,
    output logic      [N_CMP-1:0]                      regulator_out_input,
    output logic      [N_CMP-1:0]                      neg_gnd_sel,
    // Crossbar outputs
    output logic      [N_CMP-1:0]                      cmp_sync_out,
    output logic      [N_CMP-1:0]                      cmp_async_out,
    // Comparator zero triggers
    output logic                                       zero_reset_req,
    output logic                                       counter_array_kill
);

    if (N_CMP < 1 || N_CMP > 8)
    begin : g_bad_n_cmp
        $error("dcc_top: N_CMP must lie between 1 and 8");
    end

    // One-hot positive decode, cap sense, half, supply in the top bits
    function automatic logic [dcc_pkg::POS_PINS+2:0] pos_decode(
        input logic [dcc_pkg::SEL_W-1:0] code
    );
        logic [dcc_pkg::POS_PINS+2:0] d;
        d = '0;
        if (code <= dcc_pkg::POS_PIN_LAST)
            d[code] = 1'b1;
        else if (code == dcc_pkg::POS_CSENSE)
            d[dcc_pkg::POS_PINS] = 1'b1;
        else if (code == dcc_pkg::POS_HALF)
            d[dcc_pkg::POS_PINS+1] = 1'b1;
        else
            d[dcc_pkg::POS_PINS+2] = 1'b1;
        return d;
    endfunction : pos_decode

    // One-hot negative decode; the reserved code selects nothing
    function automatic logic [dcc_pkg::NEG_PINS+3:0] neg_decode(
        input logic [dcc_pkg::SEL_W-1:0] code
    );
        logic [dcc_pkg::NEG_PINS+3:0] d;
        d = '0;
        if (code <= dcc_pkg::NEG_PIN_LAST)
            d[code] = 1'b1;
        else if (code == dcc_pkg::NEG_CSENSE)
            d[dcc_pkg::NEG_PINS] = 1'b1;
        else if (code == dcc_pkg::NEG_HALF)
            d[dcc_pkg::NEG_PINS+1] = 1'b1;
        else if (code == dcc_pkg::NEG_REGOUT)
            d[dcc_pkg::NEG_PINS+2] = 1'b1;
        else if (code == dcc_pkg::NEG_GND)
            d[dcc_pkg::NEG_PINS+3] = 1'b1;
        return d;
    endfunction : neg_decode

    logic [N_CMP-1:0] sync1_r;
    logic [N_CMP-1:0] sync2_r;
    logic [N_CMP-1:0] prev_r;
    logic [N_CMP-1:0] rise_ev;
    logic [N_CMP-1:0] fall_ev;
    logic [N_CMP-1:0] rise_clr;
    logic [N_CMP-1:0] fall_clr;
    logic [N_CMP-1:0] level_nxt;
    logic [N_CMP-1:0] rise_nxt;
    logic [N_CMP-1:0] fall_nxt;

    // Gated level: a disabled comparator reads and routes as low
    assign level_nxt = sync2_r & enable_q;
    assign rise_ev   = sync2_r & enable_q & ~prev_r;
    assign fall_ev   = prev_r & ~(sync2_r & enable_q);
    assign rise_clr  = ctrl_wr & ~rise_flag_wdata;
    assign fall_clr  = ctrl_wr & ~fall_flag_wdata;
    // Set wins over a clear in the same cycle
    assign rise_nxt  = rise_ev | (rise_edge_flag & ~rise_clr);
    assign fall_nxt  = fall_ev | (fall_edge_flag & ~fall_clr);

    // Unsynchronised crossbar copy, forced low while disabled
    assign cmp_async_out = cmp_raw & enable_q;

    // Settings registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q          <= {N_CMP{dcc_pkg::ENABLE_RST}};
            rise_irq_enable_q <= {N_CMP{dcc_pkg::IRQ_EN_RST}};
            fall_irq_enable_q <= {N_CMP{dcc_pkg::IRQ_EN_RST}};
            response_mode_q   <= {N_CMP{dcc_pkg::MODE_RST}};
            pos_hyst_ctl      <= {N_CMP{dcc_pkg::HYST_RST}};
            neg_hyst_ctl      <= {N_CMP{dcc_pkg::HYST_RST}};
            pos_input_sel_q   <= {N_CMP{dcc_pkg::POS_SEL_RST}};
            neg_input_sel_q   <= {N_CMP{dcc_pkg::NEG_SEL_RST}};
        end
        else
        begin
            for (int i = 0; i < N_CMP; i++)
            begin
                if (ctrl_wr[i])
                begin
                    enable_q[i]     <= cmp_enable_bit[i];
                    pos_hyst_ctl[i] <= pos_hysteresis_sel[i];
                    neg_hyst_ctl[i] <= neg_hysteresis_sel[i];
                end
                if (mode_wr[i])
                begin
                    rise_irq_enable_q[i] <= rise_irq_enable[i];
                    fall_irq_enable_q[i] <= fall_irq_enable[i];
                    response_mode_q[i]   <= response_mode_sel[i];
                end
                if (mux_wr[i])
                begin
                    pos_input_sel_q[i] <= pos_input_sel[i];
                    neg_input_sel_q[i] <= neg_input_sel[i];
                end
            end
        end
    end

    // Analog controls follow the settings
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_power_en       <= {N_CMP{dcc_pkg::ENABLE_RST}};
            supply_current_sel <= {N_CMP{~dcc_pkg::MODE_RST}};
        end
        else
        begin
            for (int i = 0; i < N_CMP; i++)
            begin
                cmp_power_en[i]       <= enable_q[i];
                supply_current_sel[i] <= ~response_mode_q[i];
            end
        end
    end

    // Multiplexer decode, registered
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_pin_sel         <= '0;
            pos_csense_sel      <= '0;
            pos_half_sel        <= '0;
            pos_supply_sel      <= '1;
            neg_pin_sel         <= '0;
            neg_csense_sel      <= '0;
            neg_half_sel        <= '0;
            regulator_out_input <= '0;
            neg_gnd_sel         <= '1;
        end
        else
        begin
            for (int i = 0; i < N_CMP; i++)
            begin
                {pos_supply_sel[i], pos_half_sel[i], pos_csense_sel[i], pos_pin_sel[i]}
                    <= pos_decode(pos_input_sel_q[i]);
                {neg_gnd_sel[i], regulator_out_input[i], neg_half_sel[i],
                 neg_csense_sel[i], neg_pin_sel[i]}
                    <= neg_decode(neg_input_sel_q[i]);
            end
        end
    end

    // Two-stage synchroniser and previous sample
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end
        else
        begin
            sync1_r <= cmp_raw;
            sync2_r <= sync1_r;
            prev_r  <= level_nxt;
        end
    end

    // Level outputs, edge flags and interrupt
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmp_output_state <= '0;
            cmp_sync_out     <= '0;
            rise_edge_flag   <= {N_CMP{dcc_pkg::FLAG_RST}};
            fall_edge_flag   <= {N_CMP{dcc_pkg::FLAG_RST}};
            cmp_irq          <= '0;
        end
        else
        begin
            cmp_output_state <= level_nxt;
            cmp_sync_out     <= level_nxt;
            rise_edge_flag   <= rise_nxt;
            fall_edge_flag   <= fall_nxt;
            cmp_irq          <= (rise_edge_flag & rise_irq_enable_q)
                              | (fall_edge_flag & fall_irq_enable_q);
        end
    end

    // Comparator zero triggers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_reset_req     <= 1'b0;
            counter_array_kill <= 1'b0;
        end
        else
        begin
            zero_reset_req     <= level_nxt[0];
            counter_array_kill <= level_nxt[0];
        end
    end

    default clocking dcc_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    for (genvar g = 0; g < N_CMP; g++)
    begin : g_chk
        rise_sets_a : assert property (sync2_r[g] && enable_q[g] && !prev_r[g]
            |=> rise_edge_flag[g])
            else $error("rising edge did not set its flag");
        fall_sets_a : assert property (prev_r[g] && !sync2_r[g] |=> fall_edge_flag[g])
            else $error("falling edge did not set its flag");
        flag_sticky_a : assert property (rise_edge_flag[g] && !rise_clr[g]
            |=> rise_edge_flag[g])
            else $error("rising flag dropped without a clear");
        flag_clear_a : assert property (fall_edge_flag[g] && fall_clr[g] && !fall_ev[g]
            |=> !fall_edge_flag[g])
            else $error("falling flag survived a clear");
        off_low_a : assert property (!enable_q[g] && !$past(enable_q[g])
            |-> !cmp_sync_out[g] && !cmp_output_state[g] && !cmp_async_out[g])
            else $error("disabled comparator drives a high output");
        power_follow_a : assert property (ctrl_wr[g] |=> ##1 cmp_power_en[g]
            == $past(cmp_enable_bit[g], 2))
            else $error("supply control does not follow enable write");
        irq_mask_a : assert property (cmp_irq[g] == $past(
            (rise_edge_flag[g] && rise_irq_enable_q[g])
            || (fall_edge_flag[g] && fall_irq_enable_q[g])))
            else $error("interrupt does not match masked flags");
        state_level_a : assert property (cmp_output_state[g]
            == $past(sync2_r[g] && enable_q[g]))
            else $error("output state does not track the synchronised level");
        supply_code_a : assert property (pos_input_sel_q[g] >= dcc_pkg::POS_SUPPLY_A
            && $stable(pos_input_sel_q[g]) |=> pos_supply_sel[g] && pos_pin_sel[g] == '0)
            else $error("supply codes do not select the supply");
        neg_resv_a : assert property (neg_input_sel_q[g] == dcc_pkg::NEG_RESERVED
            |=> neg_pin_sel[g] == '0 && !neg_gnd_sel[g] && !regulator_out_input[g])
            else $error("reserved negative code selects an input");
        current_sel_a : assert property (supply_current_sel[g]
            == ~$past(response_mode_q[g]))
            else $error("supply current does not follow response mode");
        rise_seen_c : cover property (!rise_edge_flag[g] ##1 rise_edge_flag[g]);
        fall_seen_c : cover property (!fall_edge_flag[g] ##1 fall_edge_flag[g]);
        irq_both_c  : cover property (cmp_irq[g] && rise_irq_enable_q[g] && fall_irq_enable_q[g]);
        disable_c   : cover property (enable_q[g] ##1 !enable_q[g]);
    end

    kill_follow_a : assert property (zero_reset_req == $past(sync2_r[0] && enable_q[0])
        && counter_array_kill == zero_reset_req)
        else $error("comparator zero triggers differ from its output");

endmodule : dcc_top

// File: verif/dcc_cmp_model.sv
/*
 * Behavioural pair of analog comparator cores facing the control block.
 * Assumes the bench sets the wanted decision of each core on target.
 */
`timescale 1ns/1ps
module dcc_cmp_model #(
    parameter int N = 2
) (
    // Clock
    input  wire logic                              mclk,
    // Analog controls from the block
    input  wire logic [N-1:0]                      power_en,
    input  wire logic [N-1:0][dcc_pkg::MODE_W-1:0] cur_sel,
    // Decision wanted by the bench; chosen input pins stay analog
    input  wire logic [N-1:0]                      target,
    // Decision outputs
    output logic      [N-1:0]                      raw
);
    int unsigned lag [N];

    initial raw = '0;

    always @(posedge mclk)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!power_en[i])
            begin
                // Unpowered core output is meaningless
                raw[i] <= ~raw[i];
                lag[i] = 0;
            end
            else if (raw[i] !== target[i] && lag[i] >= 32'(3 - cur_sel[i]))
            begin
                // Less supply current, slower answer
                raw[i] <= target[i];
                lag[i] = 0;
            end
            else
                lag[i] = (raw[i] !== target[i]) ? lag[i] + 1 : 0;
        end
    end
endmodule : dcc_cmp_model

// File: verif/dual_comparator_control_tb.sv
/*
 * Self-checking bench for the dual comparator control block.
 * Assumes the design package and the comparator model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module dual_comparator_control_tb;
    localparam int N = 2;
    typedef struct {int id; logic [31:0] exp;} dcc_note_type;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [N-1:0] ctrl_wr = '0, mode_wr = '0, mux_wr = '0, target = '0, cmp_raw;
    logic [N-1:0] cmp_enable_bit = '0, rise_flag_wdata = '1, fall_flag_wdata = '1;
    logic [N-1:0] rise_irq_enable = '0, fall_irq_enable = '0;
    logic [N-1:0][1:0] pos_hysteresis_sel = '0, neg_hysteresis_sel = '0, response_mode_sel = '0;
    logic [N-1:0][3:0] pos_input_sel = '0, neg_input_sel = '0;
    logic [N-1:0] enable_q, rise_irq_enable_q, fall_irq_enable_q, cmp_output_state, cmp_irq;
    logic [N-1:0] rise_edge_flag, fall_edge_flag, cmp_power_en, pos_csense_sel, pos_half_sel;
    logic [N-1:0] pos_supply_sel, neg_csense_sel, neg_half_sel, regulator_out_input;
    logic [N-1:0] neg_gnd_sel, cmp_sync_out, cmp_async_out;
    logic [N-1:0][1:0] response_mode_q, supply_current_sel, pos_hyst_ctl, neg_hyst_ctl;
    logic [N-1:0][3:0] pos_input_sel_q, neg_input_sel_q;
    logic [N-1:0][11:0] pos_pin_sel;
    logic [N-1:0][10:0] neg_pin_sel;
    logic zero_reset_req, counter_array_kill;
    // Shadow of settings and state
    logic [N-1:0] en = '0, lvl = '0, rf = '0, ff = '0, rie = '0, fie = '0;
    logic [N-1:0][1:0] md = {2'h2, 2'h2}, hp = '0, hn = '0;
    logic [N-1:0][3:0] ps = '1, ns = '1;
    int error_cnt = 0;
    int n_compared = 0;
    dcc_note_type q[$];
    dcc_note_type nt;
    event probe;
    string nm[12] = '{"enable", "power", "level", "flags", "irq", "zero", "mode", "hyst",
                      "irq_en", "pos_dec", "neg_dec", "sel"};

    always #50 mclk = ~mclk;

    dcc_top #(.N_CMP(N)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .cmp_enable_bit(cmp_enable_bit),
        .rise_flag_wdata(rise_flag_wdata), .fall_flag_wdata(fall_flag_wdata),
        .pos_hysteresis_sel(pos_hysteresis_sel), .neg_hysteresis_sel(neg_hysteresis_sel),
        .mode_wr(mode_wr), .rise_irq_enable(rise_irq_enable), .fall_irq_enable(fall_irq_enable),
        .response_mode_sel(response_mode_sel), .mux_wr(mux_wr), .pos_input_sel(pos_input_sel),
        .neg_input_sel(neg_input_sel), .cmp_raw(cmp_raw), .enable_q(enable_q),
        .rise_irq_enable_q(rise_irq_enable_q), .fall_irq_enable_q(fall_irq_enable_q),
        .response_mode_q(response_mode_q), .pos_input_sel_q(pos_input_sel_q),
        .neg_input_sel_q(neg_input_sel_q), .cmp_output_state(cmp_output_state),
        .rise_edge_flag(rise_edge_flag), .fall_edge_flag(fall_edge_flag), .cmp_irq(cmp_irq),
        .cmp_power_en(cmp_power_en), .supply_current_sel(supply_current_sel),
        .pos_hyst_ctl(pos_hyst_ctl), .neg_hyst_ctl(neg_hyst_ctl), .pos_pin_sel(pos_pin_sel),
        .pos_csense_sel(pos_csense_sel), .pos_half_sel(pos_half_sel),
        .pos_supply_sel(pos_supply_sel), .neg_pin_sel(neg_pin_sel),
        .neg_csense_sel(neg_csense_sel), .neg_half_sel(neg_half_sel),
        .regulator_out_input(regulator_out_input), .neg_gnd_sel(neg_gnd_sel),
        .cmp_sync_out(cmp_sync_out), .cmp_async_out(cmp_async_out),
        .zero_reset_req(zero_reset_req), .counter_array_kill(counter_array_kill));

    dcc_cmp_model #(.N(N)) model_u (.mclk(mclk), .power_en(cmp_power_en),
        .cur_sel(supply_current_sel), .target(target), .raw(cmp_raw));

    function automatic logic [14:0] pdec(logic [3:0] c);
        if (c < 4'hc)
            return 15'h8 << c;
        return (c == 4'hc) ? 15'h4 : (c == 4'hd) ? 15'h2 : 15'h1;
    endfunction : pdec

    function automatic logic [14:0] ndec(logic [3:0] c);
        if (c < 4'hb)
            return 15'h10 << c;
        return (c == 4'hb) ? 15'h0 : 15'h8 >> (c - 4'hc);
    endfunction : ndec

    function automatic logic [31:0] seen(int id);
        case (id)
            0: return 32'(enable_q);
            1: return 32'(cmp_power_en);
            2: return 32'({cmp_output_state, cmp_sync_out, cmp_async_out});
            3: return 32'({rise_edge_flag, fall_edge_flag});
            4: return 32'(cmp_irq);
            5: return 32'({zero_reset_req, counter_array_kill});
            6: return 32'({supply_current_sel, response_mode_q});
            7: return 32'({pos_hyst_ctl, neg_hyst_ctl});
            8: return 32'({rise_irq_enable_q, fall_irq_enable_q});
            9: return 32'({pos_pin_sel[1], pos_csense_sel[1], pos_half_sel[1], pos_supply_sel[1],
                pos_pin_sel[0], pos_csense_sel[0], pos_half_sel[0], pos_supply_sel[0]});
            10: return 32'({neg_pin_sel[1], neg_csense_sel[1], neg_half_sel[1],
                regulator_out_input[1], neg_gnd_sel[1], neg_pin_sel[0], neg_csense_sel[0],
                neg_half_sel[0], regulator_out_input[0], neg_gnd_sel[0]});
            default: return 32'({pos_input_sel_q, neg_input_sel_q});
        endcase
    endfunction : seen

    // Note every expected output, then let the watcher compare
    task automatic note_all();
        logic [N-1:0] on;
        logic [31:0] e [12];
        on = lvl & en;
        e = '{32'(en), 32'(en), 32'({on, on, on}), 32'({rf, ff}), 32'((rf & rie) | (ff & fie)),
              32'({on[0], on[0]}), 32'({~md, md}), 32'({hp, hn}), 32'({rie, fie}),
              32'({pdec(ps[1]), pdec(ps[0])}), 32'({ndec(ns[1]), ndec(ns[0])}), 32'({ps, ns})};
        foreach (e[k])
            q.push_back('{k, e[k]});
        -> probe;
    endtask : note_all

    task automatic settle();
        repeat (8) @(negedge mclk);
    endtask : settle

    task automatic wr_ctrl(int i, logic e, logic rw, logic fw, logic [1:0] p, logic [1:0] n);
        @(negedge mclk);
        cmp_enable_bit[i] = e;
        rise_flag_wdata[i] = rw;
        fall_flag_wdata[i] = fw;
        pos_hysteresis_sel[i] = p;
        neg_hysteresis_sel[i] = n;
        ctrl_wr = N'(1) << i;
        rf[i] = rf[i] & rw;
        ff[i] = (ff[i] & fw) | (en[i] & ~e & lvl[i]);
        en[i] = e;
        hp[i] = p;
        hn[i] = n;
        @(negedge mclk);
        ctrl_wr = '0;
    endtask : wr_ctrl

    task automatic wr_mode(int i, logic re, logic fe, logic [1:0] m);
        @(negedge mclk);
        rise_irq_enable[i] = re;
        fall_irq_enable[i] = fe;
        response_mode_sel[i] = m;
        mode_wr = N'(1) << i;
        rie[i] = re;
        fie[i] = fe;
        md[i] = m;
        @(negedge mclk);
        mode_wr = '0;
    endtask : wr_mode

    task automatic wr_mux(int i, logic [3:0] p, logic [3:0] n);
        @(negedge mclk);
        pos_input_sel[i] = p;
        neg_input_sel[i] = n;
        mux_wr = N'(1) << i;
        ps[i] = p;
        ns[i] = n;
        @(negedge mclk);
        mux_wr = '0;
    endtask : wr_mux

    task automatic set_lvl(int i, logic v);
        @(negedge mclk);
        target[i] = v;
        rf[i] = rf[i] | (en[i] & v & ~lvl[i]);
        ff[i] = ff[i] | (en[i] & ~v & lvl[i]);
        lvl[i] = v;
        settle();
    endtask : set_lvl

    task automatic tally_and_finish();
        $display("compared %0d, mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    always @(probe)
    begin
        while (q.size() > 0)
        begin
            nt = q.pop_front();
            `CHK(nm[nt.id], nt.exp, seen(nt.id))
        end
    end

    initial
    begin
        repeat (4000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        void'($urandom(32'hab4a59a9));
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        settle();
        note_all();
        $display("test reset_values done");
        for (int i = 0; i < N; i++)
        begin
            wr_ctrl(i, 1, 1, 1, 0, 0);
            settle();
            wr_ctrl(i, 1, 0, 0, 0, 0);
            settle();
            note_all();
            set_lvl(i, 1);
            note_all();
            set_lvl(i, 0);
            note_all();
            wr_ctrl(i, 1, 1, 1, 0, 0);
            set_lvl(i, 1);
            note_all();
            wr_ctrl(i, 0, 0, 0, 0, 0);
            settle();
            note_all();
        end
        $display("test edges_and_enable done");
        for (int i = 0; i < N; i++)
        begin
            wr_ctrl(i, 1, 1, 1, 0, 0);
            settle();
            wr_ctrl(i, 1, 0, 0, 0, 0);
            set_lvl(i, 0);
            set_lvl(i, 1);
            for (int c = 0; c < 4; c++)
            begin
                wr_mode(i, c[0], c[1], 2'(3 - c));
                settle();
                note_all();
            end
            wr_ctrl(i, 1, 0, 1, 0, 0);
            settle();
            note_all();
            wr_mode(i, 1, 0, 2'h2);
            settle();
            note_all();
            wr_ctrl(i, 1, 1, 0, 0, 0);
            settle();
            note_all();
        end
        $display("test interrupts done");
        for (int c = 0; c < 16; c++)
        begin
            wr_mux(int'($urandom % N), 4'(c), 4'(15 - c));
            settle();
            note_all();
        end
        $display("test input_select done");
        for (int k = 0; k < 8; k++)
        begin
            wr_ctrl(k % N, en[k % N], 1, 1, 2'($urandom), 2'($urandom));
            settle();
            note_all();
        end
        $display("test hysteresis done");
        tally_and_finish();
    end
endmodule : dual_comparator_control_tb
